// >>> cgr_clock_gate_bank.sv
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
module cgr_clock_gate_bank (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [15:0] display_out_gates,
    output logic [15:0] video_in_codec_gates,
    output cgr_pkg::cgr_periph_gates_t periph_gates
);

    // =====================================================
    // apb decode
    logic access;
    logic hit_disp;
    logic hit_vin;
    logic hit_peri;
    logic mapped;
    cgr_pkg::cgr_gate_bank_t bank;

    assign access = psel && penable;
    assign hit_disp = (paddr == cgr_pkg::ADDR_DISPLAY_OUT);
    assign hit_vin = (paddr == cgr_pkg::ADDR_VIDEO_IN);
    assign hit_peri = (paddr == cgr_pkg::ADDR_PERIPH_FLASH);
    assign mapped = hit_disp || hit_vin || hit_peri;
    // zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    // =====================================================
    // gate registers
    cgr_gate_reg #(.IMPL(cgr_pkg::IMPL_DISPLAY_OUT)) u_disp (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(access && pwrite && hit_disp),
        .wdata(pwdata),
        .gates(bank.display_out)
    );

    cgr_gate_reg #(.IMPL(cgr_pkg::IMPL_VIDEO_IN)) u_vin (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(access && pwrite && hit_vin),
        .wdata(pwdata),
        .gates(bank.video_in)
    );

    cgr_gate_reg #(.IMPL(cgr_pkg::IMPL_PERIPH_FLASH)) u_peri (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(access && pwrite && hit_peri),
        .wdata(pwdata),
        .gates(bank.periph_flash)
    );

    // =====================================================
    // gate outputs; one means clock stopped
    assign display_out_gates = bank.display_out;
    assign video_in_codec_gates = bank.video_in;
    assign periph_gates.flash_host_gate = bank.periph_flash[cgr_pkg::BIT_FLASH_HOST];
    assign periph_gates.flash_core_gate = bank.periph_flash[cgr_pkg::BIT_FLASH_CORE];
    assign periph_gates.flash_ctrl_slow_path_gate =
        bank.periph_flash[cgr_pkg::BIT_FLASH_SLOW];
    assign periph_gates.flash_pll_gate = bank.periph_flash[cgr_pkg::BIT_FLASH_PLL];
    assign periph_gates.peri_interconnect_gate = bank.periph_flash[cgr_pkg::BIT_PERI_NIU];
    assign periph_gates.peri_bus_gate = bank.periph_flash[cgr_pkg::BIT_PERI_BUS];
    assign periph_gates.peri_pll_root_gate = bank.periph_flash[cgr_pkg::BIT_PERI_PLL];

    // =====================================================
    // read data, registered; mask half always reads zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
        begin
            if (paddr == cgr_pkg::ADDR_DISPLAY_OUT)
                prdata <= {16'h0000, bank.display_out};
            else if (paddr == cgr_pkg::ADDR_VIDEO_IN)
                prdata <= {16'h0000, bank.video_in};
            else if (paddr == cgr_pkg::ADDR_PERIPH_FLASH)
                prdata <= {16'h0000, bank.periph_flash};
            else
                prdata <= 32'h0000_0000;
        end
    end

    // =====================================================
    // checks
    sequence s_write_peri;
        psel && penable && pwrite && hit_peri;
    endsequence

    sequence s_write_disp;
        psel && penable && pwrite && hit_disp;
    endsequence

    sequence s_write_vin;
        psel && penable && pwrite && hit_vin;
    endsequence

    sequence s_read_setup_disp;
        psel && !penable && !pwrite && hit_disp;
    endsequence

    sequence s_read_setup_vin;
        psel && !penable && !pwrite && hit_vin;
    endsequence

    sequence s_read_setup_peri;
        psel && !penable && !pwrite && hit_peri;
    endsequence

    chk_masked_bit_update: assert property (@(posedge pclk) disable iff (!presetn)
        s_write_peri and pwdata[cgr_pkg::MASK_LSB + cgr_pkg::BIT_FLASH_HOST]
        |=> periph_gates.flash_host_gate == $past(pwdata[cgr_pkg::BIT_FLASH_HOST]))
        else $error("masked write did not update gate");

    chk_unmasked_bit_hold: assert property (@(posedge pclk) disable iff (!presetn)
        s_write_peri and !pwdata[cgr_pkg::MASK_LSB + cgr_pkg::BIT_PERI_BUS]
        |=> $stable(periph_gates.peri_bus_gate))
        else $error("unmasked gate bit changed");

    chk_gate_no_write: assert property (@(posedge pclk) disable iff (!presetn)
        !(access && pwrite) |=> $stable(bank))
        else $error("gate changed without a write");

    chk_disp_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        bank.display_out[15:10] == 6'h00)
        else $error("display reserved bits set");

    chk_vin_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        !bank.video_in[10] && !bank.video_in[3])
        else $error("video-in reserved bits set");

    chk_peri_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (bank.periph_flash & ~cgr_pkg::IMPL_PERIPH_FLASH) == 16'h0000)
        else $error("peripheral reserved bits set");

    chk_flash_slow_map: assert property (@(posedge pclk) disable iff (!presetn)
        s_write_peri and pwdata[cgr_pkg::MASK_LSB + cgr_pkg::BIT_FLASH_SLOW]
        |=> periph_gates.flash_ctrl_slow_path_gate == $past(pwdata[cgr_pkg::BIT_FLASH_SLOW]))
        else $error("flash slow path gate mismatch");

    chk_read_mask_zero: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite |=> prdata[31:16] == 16'h0000)
        else $error("mask field read nonzero");

    // =====================================================
    // per-bit checks; every implemented bit obeys its own mask bit
    generate
        for (genvar b = 0; b < cgr_pkg::GATE_W; b++)
        begin : g_chk_disp
            if (cgr_pkg::IMPL_DISPLAY_OUT[b])
            begin : g_impl
                chk_disp_bit_set: assert property (@(posedge pclk) disable iff (!presetn)
                    s_write_disp and pwdata[cgr_pkg::MASK_LSB + b]
                    |=> display_out_gates[b] == $past(pwdata[b]))
                    else $error("display gate bit not written");
                chk_disp_bit_hold: assert property (@(posedge pclk) disable iff (!presetn)
                    s_write_disp and !pwdata[cgr_pkg::MASK_LSB + b]
                    |=> $stable(display_out_gates[b]))
                    else $error("display gate bit changed without mask");
            end
            else
            begin : g_rsvd
                chk_disp_bit_rsvd: assert property (@(posedge pclk) disable iff (!presetn)
                    display_out_gates[b] == 1'b0)
                    else $error("display reserved gate bit set");
            end
        end
    endgenerate

    generate
        for (genvar b = 0; b < cgr_pkg::GATE_W; b++)
        begin : g_chk_vin
            if (cgr_pkg::IMPL_VIDEO_IN[b])
            begin : g_impl
                chk_vin_bit_set: assert property (@(posedge pclk) disable iff (!presetn)
                    s_write_vin and pwdata[cgr_pkg::MASK_LSB + b]
                    |=> video_in_codec_gates[b] == $past(pwdata[b]))
                    else $error("video-in gate bit not written");
                chk_vin_bit_hold: assert property (@(posedge pclk) disable iff (!presetn)
                    s_write_vin and !pwdata[cgr_pkg::MASK_LSB + b]
                    |=> $stable(video_in_codec_gates[b]))
                    else $error("video-in gate bit changed without mask");
            end
            else
            begin : g_rsvd
                chk_vin_bit_rsvd: assert property (@(posedge pclk) disable iff (!presetn)
                    video_in_codec_gates[b] == 1'b0)
                    else $error("video-in reserved gate bit set");
            end
        end
    endgenerate

    generate
        for (genvar b = 0; b < cgr_pkg::GATE_W; b++)
        begin : g_chk_peri
            if (cgr_pkg::IMPL_PERIPH_FLASH[b])
            begin : g_impl
                chk_peri_bit_set: assert property (@(posedge pclk) disable iff (!presetn)
                    s_write_peri and pwdata[cgr_pkg::MASK_LSB + b]
                    |=> bank.periph_flash[b] == $past(pwdata[b]))
                    else $error("peripheral gate bit not written");
                chk_peri_bit_hold: assert property (@(posedge pclk) disable iff (!presetn)
                    s_write_peri and !pwdata[cgr_pkg::MASK_LSB + b]
                    |=> $stable(bank.periph_flash[b]))
                    else $error("peripheral gate bit changed without mask");
            end
            else
            begin : g_rsvd
                chk_peri_bit_rsvd: assert property (@(posedge pclk) disable iff (!presetn)
                    bank.periph_flash[b] == 1'b0)
                    else $error("peripheral reserved gate bit set");
            end
        end
    endgenerate

    // =====================================================
    // output mapping of the peripheral/flash gates
    chk_flash_host_map: assert property (@(posedge pclk) disable iff (!presetn)
        s_write_peri and pwdata[cgr_pkg::MASK_LSB + cgr_pkg::BIT_FLASH_HOST]
        |=> periph_gates.flash_host_gate == $past(pwdata[cgr_pkg::BIT_FLASH_HOST]))
        else $error("flash host gate mismatch");

    chk_flash_core_map: assert property (@(posedge pclk) disable iff (!presetn)
        s_write_peri and pwdata[cgr_pkg::MASK_LSB + cgr_pkg::BIT_FLASH_CORE]
        |=> periph_gates.flash_core_gate == $past(pwdata[cgr_pkg::BIT_FLASH_CORE]))
        else $error("flash core gate mismatch");

    chk_flash_pll_map: assert property (@(posedge pclk) disable iff (!presetn)
        s_write_peri and pwdata[cgr_pkg::MASK_LSB + cgr_pkg::BIT_FLASH_PLL]
        |=> periph_gates.flash_pll_gate == $past(pwdata[cgr_pkg::BIT_FLASH_PLL]))
        else $error("flash pll gate mismatch");

    chk_peri_niu_map: assert property (@(posedge pclk) disable iff (!presetn)
        s_write_peri and pwdata[cgr_pkg::MASK_LSB + cgr_pkg::BIT_PERI_NIU]
        |=> periph_gates.peri_interconnect_gate == $past(pwdata[cgr_pkg::BIT_PERI_NIU]))
        else $error("peripheral interconnect gate mismatch");

    chk_peri_bus_map: assert property (@(posedge pclk) disable iff (!presetn)
        s_write_peri and pwdata[cgr_pkg::MASK_LSB + cgr_pkg::BIT_PERI_BUS]
        |=> periph_gates.peri_bus_gate == $past(pwdata[cgr_pkg::BIT_PERI_BUS]))
        else $error("peripheral bus gate mismatch");

    chk_peri_pll_map: assert property (@(posedge pclk) disable iff (!presetn)
        s_write_peri and pwdata[cgr_pkg::MASK_LSB + cgr_pkg::BIT_PERI_PLL]
        |=> periph_gates.peri_pll_root_gate == $past(pwdata[cgr_pkg::BIT_PERI_PLL]))
        else $error("peripheral pll root gate mismatch");

    // =====================================================
    // a write to one register leaves the others alone
    chk_disp_write_isolated: assert property (@(posedge pclk) disable iff (!presetn)
        s_write_disp |=> $stable(bank.video_in) && $stable(bank.periph_flash))
        else $error("display write disturbed another register");

    chk_vin_write_isolated: assert property (@(posedge pclk) disable iff (!presetn)
        s_write_vin |=> $stable(bank.display_out) && $stable(bank.periph_flash))
        else $error("video-in write disturbed another register");

    chk_peri_write_isolated: assert property (@(posedge pclk) disable iff (!presetn)
        s_write_peri |=> $stable(bank.display_out) && $stable(bank.video_in))
        else $error("peripheral write disturbed another register");

    chk_read_no_gate_change: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pwrite |=> $stable(bank))
        else $error("read changed a gate");

    // =====================================================
    // read data; taken at the setup edge, shown in the access phase
    chk_read_disp_data: assert property (@(posedge pclk) disable iff (!presetn)
        s_read_setup_disp |=> prdata == {16'h0000, $past(bank.display_out)})
        else $error("display read data mismatch");

    chk_read_vin_data: assert property (@(posedge pclk) disable iff (!presetn)
        s_read_setup_vin |=> prdata == {16'h0000, $past(bank.video_in)})
        else $error("video-in read data mismatch");

    chk_read_peri_data: assert property (@(posedge pclk) disable iff (!presetn)
        s_read_setup_peri |=> prdata == {16'h0000, $past(bank.periph_flash)})
        else $error("peripheral read data mismatch");

    chk_read_peri_low_zero: assert property (@(posedge pclk) disable iff (!presetn)
        s_read_setup_peri |=> prdata[4:0] == 5'h00)
        else $error("peripheral low bits read nonzero");

    chk_read_unmapped_zero: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && !mapped |=> prdata == 32'h0000_0000)
        else $error("unmapped read nonzero");

    chk_read_data_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data changed outside a read setup");

    // =====================================================
    // handshake and error response
    chk_ready_high: assert property (@(posedge pclk) disable iff (!presetn)
        pready == 1'b1)
        else $error("ready low");

    chk_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !mapped |-> pslverr)
        else $error("no error on unmapped access");

    chk_err_mapped_clear: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && mapped |-> !pslverr)
        else $error("error on mapped access");

    chk_err_setup_low: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable |-> !pslverr)
        else $error("error raised in setup cycle");

    chk_err_idle_low: assert property (@(posedge pclk) disable iff (!presetn)
        !psel |-> !pslverr)
        else $error("error raised while idle");

    chk_unmapped_write_ignored: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pwrite && !mapped |=> $stable(bank))
        else $error("unmapped write changed a gate");

endmodule

// >>> cgr_clock_gate_bank_test.sv
`timescale 1ns/1ps
module cgr_clock_gate_bank_test;
    // ==========================================
    // stimulus and scoreboard state
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] display_out_gates;
    logic [15:0] video_in_codec_gates;
    cgr_pkg::cgr_periph_gates_t periph_gates;
    int fails = 0;
    int checks = 0;
    logic [32:0] expq[$];
    logic [15:0] m[4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] impl[4] = '{cgr_pkg::IMPL_DISPLAY_OUT, cgr_pkg::IMPL_VIDEO_IN,
                             cgr_pkg::IMPL_PERIPH_FLASH, 16'h0000};
    logic [11:0] adr[4] = '{cgr_pkg::ADDR_DISPLAY_OUT, cgr_pkg::ADDR_VIDEO_IN,
                            cgr_pkg::ADDR_PERIPH_FLASH, 12'h218};
    logic [31:0] rng = 32'h2814CD72;
    logic [32:0] e;
    always #12.5 pclk = ~pclk;
    cgr_clock_gate_bank u_cgr_clock_gate_bank (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .display_out_gates(display_out_gates),
        .video_in_codec_gates(video_in_codec_gates), .periph_gates(periph_gates));
    // ==========================================
    // helpers
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction
    task automatic chk(input string name, input logic [32:0] seen, input logic [32:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // one idle edge first so psel is never assigned twice in a time step
    task automatic op(input logic wr, input int k, input logic [31:0] d);
        int n;
        n = 0;
        if (wr)
            m[k] = (m[k] & ~d[31:16]) | (d[15:0] & d[31:16] & impl[k]);
        else
            expq.push_back({k == 3, 16'h0000, m[k]});
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= adr[k];
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
            fails++;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
        chk("display_out_gates", {17'h0, display_out_gates}, {17'h0, m[0]});
        chk("video_in_codec_gates", {17'h0, video_in_codec_gates}, {17'h0, m[1]});
        chk("periph_gates", {26'h0, periph_gates}, {26'h0, m[2][15], m[2][13:11], m[2][9:7]});
    endtask
    // ==========================================
    // read monitor
    always @(posedge pclk)
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            e = expq.pop_front();
            chk("read", {pslverr, prdata}, e);
        end
    // ==========================================
    // sequence
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 4; k++)
            op(1'b0, k, 32'h0);
        for (int k = 0; k < 4; k++)
        begin
            op(1'b1, k, 32'h0000FFFF);
            op(1'b1, k, 32'hFFFFFFFF);
            op(1'b0, k, 32'h0);
        end
        for (int i = 0; i < 80; i++)
            op(xs() % 2, xs() % 4, xs());
        repeat (2) @(posedge pclk);
        end_sim();
    end
    initial
    begin
        repeat (2000) @(posedge pclk);
        fails++;
        end_sim();
    end
endmodule

// >>> cgr_gate_reg.sv
`timescale 1ns/1ps
module cgr_gate_reg #(
    parameter logic [15:0] IMPL = 16'hFFFF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_en,
    input wire logic [31:0] wdata,
    output logic [15:0] gates
);

    // =====================================================
    // masked per-bit update
    genvar i;
    generate
        for (i = 0; i < cgr_pkg::GATE_W; i++)
        begin : g_bit
            if (IMPL[i])
            begin : g_impl
                always_ff @(posedge pclk or negedge presetn)
                begin
                    if (!presetn)
                        gates[i] <= cgr_pkg::GATE_RESET[i];
                    else if (wr_en && wdata[cgr_pkg::MASK_LSB + i])
                        gates[i] <= wdata[i];
                end
            end
            else
            begin : g_rsvd
                assign gates[i] = 1'b0;
            end
        end
    endgenerate

endmodule

// >>> cgr_pkg.sv
// Behaviour
// - a write updates gate bit n only where mask bit n+16 is one
// - gate bits whose mask bit is zero keep their value
// - a gate bit at one stops its clock; all gates reset to zero
// - display-out register holds gate bits 9:0; bits 15:10 reserved
// - video-in/codec register holds bits 15:11, 9:4, 2:0; 10 and 3 reserved
// - peripheral/flash register holds bits 15, 13:11, 9:7; 14, 10, 6:5 reserved
// - bit 15 gates flash host bus clock, bit 13 its core clock
// - bit 12 gates flash slow path, bit 11 its pll clock
// - bits 9, 8, 7 gate peripheral interconnect, bus and pll root clocks
package cgr_pkg;

    // =====================================================
    // register map
    localparam logic [11:0] ADDR_DISPLAY_OUT = 12'h20C;
    localparam logic [11:0] ADDR_VIDEO_IN = 12'h210;
    localparam logic [11:0] ADDR_PERIPH_FLASH = 12'h214;
    localparam int NUM_REGS = 3;
    localparam int GATE_W = 16;
    localparam int MASK_LSB = 16;
    localparam logic [15:0] GATE_RESET = 16'h0000;

    // =====================================================
    // implemented gate bits per register
    localparam logic [15:0] IMPL_DISPLAY_OUT = 16'h03FF;
    localparam logic [15:0] IMPL_VIDEO_IN = 16'hFBF7;
    // bits 4:0 live outside this block and read as zero here
    localparam logic [15:0] IMPL_PERIPH_FLASH = 16'hBB80;

    // =====================================================
    // bit positions in the peripheral/flash register
    localparam int BIT_FLASH_HOST = 15;
    localparam int BIT_FLASH_CORE = 13;
    localparam int BIT_FLASH_SLOW = 12;
    localparam int BIT_FLASH_PLL = 11;
    localparam int BIT_PERI_NIU = 9;
    localparam int BIT_PERI_BUS = 8;
    localparam int BIT_PERI_PLL = 7;

    // =====================================================
    // carriers
    typedef struct packed {
        logic flash_host_gate;
        logic flash_core_gate;
        logic flash_ctrl_slow_path_gate;
        logic flash_pll_gate;
        logic peri_interconnect_gate;
        logic peri_bus_gate;
        logic peri_pll_root_gate;
    } cgr_periph_gates_t;

    typedef struct packed {
        logic [15:0] display_out;
        logic [15:0] video_in;
        logic [15:0] periph_flash;
    } cgr_gate_bank_t;

endpackage
